// [core/fpec_ctrl.sv]
// flash program/erase controller with avalon-mm register slave
//
// Behaviour
// [R1] array is 8, 16 or 32 pages of 1024 bytes each; this design has 32 pages only
// [R2] page is the erase unit, 16-bit word the program unit
// [R3] programming addresses words with a 14-bit address from high and low registers
// [R4] page erase takes the page from address high bits 5 down to 1
// [R5] cpu reads see bytes, controller program and erase use word addresses
// [R6] writing one to the program start bit begins programming at the loaded address
// [R7] programming only clears bits, a one over a zero is ignored
// [R8] erase sets every bit to one, page or debug chip erase only
// [R9] program data comes from dma or cpu register writes
// [R10] word busy flag stays high while each word is programmed
// [R11] first data byte is the low byte, second the high byte
// [R12] a word is programmed each time two bytes arrive, so bytes come paired
// [R13] page erase about 20 ms, chip erase 200 ms, word program 20 us
// [R14] flash powers down between reads while the cpu clock is divided
// [R15] byte pair missing 40 us after start or busy fall aborts, address kept
// [R16] erase started together with program finishes before programming begins
// [R17] program start raises first dma request, then one whenever data is accepted; after a high byte the request comes when the word finishes programming
// [R18] six-bit timing setting resets to 0x11 and software adjusts it
// [R19] after each word the address steps by one and busy clears
//
// Added by the designer: the address map and the Avalon-MM slave port.
`default_nettype none
`include "fpec_regs.svh"
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int PAGE_TICKS = `FPEC_PAGE_TICKS,
  parameter int CHIP_TICKS = `FPEC_CHIP_TICKS
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [3:0]         avs_byteenable,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    irq,
  output logic                    dma_req,
  input  wire logic               dbg_chip_erase,
  input  wire logic               cpu_rd,
  input  wire logic [14:0]        cpu_rd_addr,
  output logic [7:0]              cpu_rd_byte,
  output logic [13:0]             flash_rd_addr,
  input  wire logic [15:0]        flash_rdata,
  output fpec_flash_cmd_type      flash_cmd,
  output logic                    flash_pwr_dn
);

  fpec_state_type     st_ff;
  fpec_flash_cmd_type cmd_ff;
  logic [31:0] rdata_ff;
  logic        ack_ff;
  logic        dma_ff;
  logic [5:0]  addrh_ff;
  logic [7:0]  addrl_ff;
  logic [5:0]  timing_ff;
  logic [2:0]  clkdiv_ff;
  logic [2:0]  stat_ff;
  logic [2:0]  mask_ff;
  logic [7:0]  low_ff;
  logic        half_ff;
  logic        pend_prog_ff;
  logic [5:0]  tick_cnt_ff;
  logic [17:0] op_cnt_ff;
  logic [13:0] rd_addr_ff;
  logic        rd_lsb_ff;
  logic [7:0]  rd_byte_ff;
  logic        pwr_dn_ff;
  logic [13:0] word_addr;
  logic        req;
  logic        stall;
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_wdata;
  logic        tick;
  logic [5:0]  fwt_m1;
  logic [17:0] target;
  logic        op_done;
  logic        tmo;
  logic        byte_hi;
  logic [2:0]  ev;

  assign word_addr = {addrh_ff, addrl_ff}; // R3

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, data-port writes held off while a word programs

  assign req      = avs_read | avs_write;
  assign wr_ctrl  = wr_en & avs_address == `FPEC_OFS_CTRL;
  assign wr_wdata = wr_en & avs_address == `FPEC_OFS_WDATA;
  // back-pressure on data port keeps bytes from landing mid-program
  assign stall    = avs_write & avs_address == `FPEC_OFS_WDATA & st_ff == ST_PROG; // R12
  assign wr_en    = avs_write & ack_ff & avs_byteenable[0];
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff & ~stall;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & ~ack_ff) begin
      case (avs_address)
        `FPEC_OFS_CTRL:     rdata_ff <= {24'h00_0000, st_ff != ST_IDLE, st_ff == ST_PROG,
                                         6'h00}; // R10
        `FPEC_OFS_ADDRL:    rdata_ff <= {24'h00_0000, addrl_ff};
        `FPEC_OFS_ADDRH:    rdata_ff <= {26'h000_0000, addrh_ff};
        `FPEC_OFS_TIMING:   rdata_ff <= {26'h000_0000, timing_ff};
        `FPEC_OFS_CLKDIV:   rdata_ff <= {29'h0000_0000, clkdiv_ff};
        `FPEC_OFS_IRQ_STAT: rdata_ff <= {29'h0000_0000, stat_ff};
        `FPEC_OFS_IRQ_MASK: rdata_ff <= {29'h0000_0000, mask_ff};
        default:            rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timing_ff <= `FPEC_TIMING_RST; // R18
      clkdiv_ff <= 3'h0;
      mask_ff   <= 3'h0;
    end else if (wr_en) begin
      if (avs_address == `FPEC_OFS_TIMING) begin
        timing_ff <= avs_writedata[5:0]; // R18
      end
      if (avs_address == `FPEC_OFS_CLKDIV) begin
        clkdiv_ff <= avs_writedata[2:0];
      end
      if (avs_address == `FPEC_OFS_IRQ_MASK) begin
        mask_ff <= avs_writedata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: a new event beats a write-one clear in the same cycle

  assign ev[`FPEC_IRQ_WORD]  = st_ff == ST_PROG & op_done;
  assign ev[`FPEC_IRQ_ERASE] = st_ff == ST_ERASE & op_done;
  assign ev[`FPEC_IRQ_TMO]   = tmo;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff <= (stat_ff & ~({3{wr_en & avs_address == `FPEC_OFS_IRQ_STAT}}
                 & avs_writedata[2:0])) | ev;
    end
  end

  assign irq = |(stat_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // timing generator: tick about every 1.3 us when timing matches the clock

  assign fwt_m1  = (timing_ff == 6'h00) ? 6'h00 : timing_ff - 6'h01;
  assign tick    = tick_cnt_ff >= fwt_m1; // a lowered setting must not wait out a full wrap
  // one counter serves all phases; target follows the phase
  assign target  = (st_ff == ST_PROG) ? 18'(`FPEC_WORD_TICKS) :
                   (st_ff == ST_WAITB) ? 18'(`FPEC_TMO_TICKS) :
                   cmd_ff.chip ? 18'(CHIP_TICKS) : 18'(PAGE_TICKS); // R13
  assign op_done = tick & op_cnt_ff == target - 18'h00001; // R13
  assign tmo     = st_ff == ST_WAITB & op_done & ~(wr_wdata & half_ff); // R15

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_ff <= 6'h00;
    end else begin
      tick_cnt_ff <= tick ? 6'h00 : tick_cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_cnt_ff <= 18'h00000;
    end else if (st_ff == ST_IDLE | op_done | (st_ff == ST_WAITB & wr_wdata & half_ff)) begin
      op_cnt_ff <= 18'h00000;
    end else if (tick) begin
      op_cnt_ff <= op_cnt_ff + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign byte_hi = st_ff == ST_WAITB & wr_wdata & half_ff; // R12

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff        <= ST_IDLE;
      pend_prog_ff <= 1'b0;
      half_ff      <= 1'b0;
      low_ff       <= 8'h00;
      dma_ff       <= 1'b0;
      cmd_ff       <= '0;
    end else begin
      dma_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          half_ff <= 1'b0;
          if (wr_ctrl & avs_writedata[`FPEC_CTRL_ERASE]) begin
            st_ff        <= ST_ERASE; // R16
            pend_prog_ff <= avs_writedata[`FPEC_CTRL_PROG];
            cmd_ff.erase <= 1'b1; // R8
            cmd_ff.addr  <= {addrh_ff[5:1], 9'h000}; // R1 R2 R4
          end else if (wr_ctrl & avs_writedata[`FPEC_CTRL_PROG]) begin
            st_ff  <= ST_WAITB; // R6
            dma_ff <= 1'b1; // R17
          end else if (dbg_chip_erase) begin
            st_ff        <= ST_ERASE;
            cmd_ff.erase <= 1'b1; // R8
            cmd_ff.chip  <= 1'b1;
          end
        end
        ST_ERASE: begin
          if (op_done) begin
            cmd_ff.erase <= 1'b0;
            cmd_ff.chip  <= 1'b0;
            pend_prog_ff <= 1'b0;
            st_ff        <= pend_prog_ff ? ST_WAITB : ST_IDLE; // R16
            dma_ff       <= pend_prog_ff; // R17
          end
        end
        ST_WAITB: begin
          if (tmo) begin
            st_ff <= ST_IDLE; // R15
          end else if (wr_wdata & ~half_ff) begin
            low_ff  <= avs_writedata[7:0]; // R9 R11
            half_ff <= 1'b1;
            dma_ff  <= 1'b1; // R17
          end else if (byte_hi) begin
            half_ff       <= 1'b0;
            st_ff         <= ST_PROG; // R10
            cmd_ff.prog   <= 1'b1;
            cmd_ff.addr   <= word_addr; // R3
            // old contents gate the word so a zero never turns back to one
            cmd_ff.wdata  <= {avs_writedata[7:0], low_ff} & flash_rdata; // R7 R11
          end
        end
        ST_PROG: begin
          if (op_done) begin
            cmd_ff.prog <= 1'b0; // R19
            st_ff       <= ST_WAITB;
            dma_ff      <= 1'b1; // R17
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign flash_cmd = cmd_ff;
  assign dma_req   = dma_ff;

  // address: software loads it, hardware steps it after each word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addrh_ff <= 6'h00;
      addrl_ff <= 8'h00;
    end else if (st_ff == ST_PROG & op_done) begin
      {addrh_ff, addrl_ff} <= word_addr + 14'h0001; // R19
    end else if (wr_en & st_ff == ST_IDLE) begin
      if (avs_address == `FPEC_OFS_ADDRL) begin
        addrl_ff <= avs_writedata[7:0];
      end
      if (avs_address == `FPEC_OFS_ADDRH) begin
        addrh_ff <= avs_writedata[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu byte reads and power-down; the array is busy while writing

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_addr_ff <= 14'h0000;
      rd_lsb_ff  <= 1'b0;
      rd_byte_ff <= 8'h00;
      pwr_dn_ff  <= 1'b0;
    end else begin
      rd_addr_ff <= (st_ff == ST_IDLE) ? cpu_rd_addr[14:1] : word_addr; // R5
      rd_lsb_ff  <= cpu_rd_addr[0];
      rd_byte_ff <= rd_lsb_ff ? flash_rdata[15:8] : flash_rdata[7:0]; // R5
      pwr_dn_ff  <= clkdiv_ff != 3'h0 & ~cpu_rd & st_ff == ST_IDLE; // R14
    end
  end

  assign flash_rd_addr = rd_addr_ff;
  assign cpu_rd_byte   = rd_byte_ff;
  assign flash_pwr_dn  = pwr_dn_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_step_addr;
    @(posedge sys_clk) disable iff (rst)
    st_ff == ST_PROG && op_done |=> word_addr == $past(word_addr) + 14'h0001
      && st_ff == ST_WAITB && dma_req;
  endproperty
  a_step_addr: assert property (p_step_addr) else $error("address not stepped"); // R19

  property p_busy;
    @(posedge sys_clk) disable iff (rst)
    flash_cmd.prog |-> st_ff == ST_PROG && flash_cmd.addr == word_addr;
  endproperty
  a_busy: assert property (p_busy) else $error("program without busy"); // R10

  property p_pack;
    @(posedge sys_clk) disable iff (rst)
    byte_hi |=> flash_cmd.prog && flash_cmd.wdata == ({$past(avs_writedata[7:0]),
      $past(low_ff)} & $past(flash_rdata));
  endproperty
  a_pack: assert property (p_pack) else $error("word packed wrong"); // R7 R11

  property p_erase_first;
    @(posedge sys_clk) disable iff (rst)
    st_ff == ST_IDLE && wr_ctrl && avs_writedata[`FPEC_CTRL_ERASE]
      && avs_writedata[`FPEC_CTRL_PROG] |=> st_ff == ST_ERASE && flash_cmd.erase
      && !flash_cmd.prog;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("erase not first"); // R16

  property p_page;
    @(posedge sys_clk) disable iff (rst)
    $rose(flash_cmd.erase) && !flash_cmd.chip |->
      flash_cmd.addr[13:`FPEC_PAGE_LSB] == $past(addrh_ff[5:1]);
  endproperty
  a_page: assert property (p_page) else $error("wrong erase page"); // R4

  property p_timeout;
    @(posedge sys_clk) disable iff (rst)
    tmo |=> st_ff == ST_IDLE && stat_ff[`FPEC_IRQ_TMO] && word_addr == $past(word_addr);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not handled"); // R15

  property p_first_dma;
    @(posedge sys_clk) disable iff (rst)
    st_ff == ST_IDLE && wr_ctrl && !avs_writedata[`FPEC_CTRL_ERASE]
      && avs_writedata[`FPEC_CTRL_PROG] |=> dma_req ##1 !dma_req;
  endproperty
  a_first_dma: assert property (p_first_dma) else $error("no first dma request"); // R17

  property p_pwr;
    @(posedge sys_clk) disable iff (rst)
    flash_pwr_dn |-> $past(st_ff == ST_IDLE) && $past(clkdiv_ff) != 3'h0 && !$past(cpu_rd);
  endproperty
  a_pwr: assert property (p_pwr) else $error("bad power-down"); // R14

  property p_irq;
    @(posedge sys_clk) disable iff (rst)
    ev != 3'h0 |=> (stat_ff & $past(ev)) == $past(ev);
  endproperty
  a_irq: assert property (p_irq) else $error("event lost");

endmodule
`default_nettype wire

// [include/fpec_pkg.sv]
// types shared by the flash program/erase controller
`default_nettype none
package fpec_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_WAITB = 4'b0100,
    ST_PROG  = 4'b1000
  } fpec_state_type;
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic        chip;
    logic [13:0] addr;
    logic [15:0] wdata;
  } fpec_flash_cmd_type;
endpackage
`default_nettype wire

// [include/fpec_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH
`define FPEC_OFS_CTRL     5'h00
`define FPEC_OFS_WDATA    5'h04
`define FPEC_OFS_ADDRL    5'h08
`define FPEC_OFS_ADDRH    5'h0C
`define FPEC_OFS_TIMING   5'h10
`define FPEC_OFS_CLKDIV   5'h14
`define FPEC_OFS_IRQ_STAT 5'h18
`define FPEC_OFS_IRQ_MASK 5'h1C
`define FPEC_CTRL_ERASE   0
`define FPEC_CTRL_PROG    1
`define FPEC_CTRL_WBUSY   6
`define FPEC_CTRL_BUSY    7
`define FPEC_IRQ_WORD     0
`define FPEC_IRQ_ERASE    1
`define FPEC_IRQ_TMO      2
`define FPEC_TIMING_RST   6'h11
`define FPEC_NUM_PAGES    32
`define FPEC_PAGE_BYTES   1024
`define FPEC_PAGE_LSB     9
`define FPEC_TICK_NS      1313
`define FPEC_WORD_NS      20000
`define FPEC_PAGE_NS      20000000
`define FPEC_CHIP_NS      200000000
`define FPEC_TMO_NS       40000
`define FPEC_WORD_TICKS   (`FPEC_WORD_NS / `FPEC_TICK_NS)
`define FPEC_PAGE_TICKS   (`FPEC_PAGE_NS / `FPEC_TICK_NS)
`define FPEC_CHIP_TICKS   (`FPEC_CHIP_NS / `FPEC_TICK_NS)
`define FPEC_TMO_TICKS    ((`FPEC_TMO_NS + `FPEC_TICK_NS - 1) / `FPEC_TICK_NS)
`endif

// [testbench/fpec_flash_model.sv]
// flash array model driven by the controller's command struct
`default_nettype none
module fpec_flash_model
  import fpec_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire fpec_flash_cmd_type flash_cmd,
  input  wire logic [13:0]        flash_rd_addr,
  output logic [15:0]             flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:16383];
  logic        prog_q;
  logic        erase_q;
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 16'hFFFF;
    prog_q = 1'b0;
    erase_q = 1'b0;
  end
  // combinational read port, same cycle as the address
  assign flash_rdata = mem[flash_rd_addr];
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    prog_q <= flash_cmd.prog;
    erase_q <= flash_cmd.erase;
    // cells can only be pulled to zero
    if (flash_cmd.prog && !prog_q) begin
      mem[flash_cmd.addr] <= mem[flash_cmd.addr] & flash_cmd.wdata;
    end
    if (flash_cmd.erase && !erase_q) begin
      for (int i = 0; i < 16384; i++) begin
        if (flash_cmd.chip || i[13:9] == flash_cmd.addr[13:9]) mem[i] <= 16'hFFFF;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/test_flash_program_erase_controller.sv]
// self-checking bench for the flash program/erase controller
`default_nettype none
`include "fpec_regs.svh"
module test_flash_program_erase_controller
  import fpec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk, rst, avs_read, avs_write, irq, dma_req, dbg_chip_erase, cpu_rd;
  logic               avs_waitrequest, flash_pwr_dn;
  logic [4:0]         avs_address;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_writedata, avs_readdata;
  logic [14:0]        cpu_rd_addr;
  logic [7:0]         cpu_rd_byte;
  logic [13:0]        flash_rd_addr;
  logic [15:0]        flash_rdata;
  fpec_flash_cmd_type flash_cmd, c;
  int                 mismatches, n_checks, dma_cnt, len;
  fpec_ctrl #(.PAGE_TICKS(20), .CHIP_TICKS(40)) DUT (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .dma_req(dma_req), .dbg_chip_erase(dbg_chip_erase), .cpu_rd(cpu_rd),
    .cpu_rd_addr(cpu_rd_addr), .cpu_rd_byte(cpu_rd_byte), .flash_rd_addr(flash_rd_addr),
    .flash_rdata(flash_rdata), .flash_cmd(flash_cmd), .flash_pwr_dn(flash_pwr_dn));
  fpec_flash_model u_array (.sys_clk(sys_clk), .flash_cmd(flash_cmd),
    .flash_rd_addr(flash_rd_addr), .flash_rdata(flash_rdata));
  always #4 sys_clk = ~sys_clk;
  // one-cycle pulses, so a mid-cycle sample counts each exactly once
  always @(negedge sys_clk) if (dma_req === 1'b1) dma_cnt++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // waits for prog or erase, keeps the command seen first, counts high cycles
  task automatic meas(input logic er);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((er ? flash_cmd.erase : flash_cmd.prog) !== 1'b1 && n < 2000);
    c = flash_cmd;
    len = 0;
    while ((er ? flash_cmd.erase : flash_cmd.prog) === 1'b1 && len < 2000) begin
      len++;
      @(negedge sys_clk);
    end
  endtask
  task automatic cpu_chk(input logic [14:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cpu_rd <= 1'b1;
    cpu_rd_addr <= a;
    repeat (3) @(negedge sys_clk);
    chk(32'(cpu_rd_byte), 32'(e));
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
  endtask
  task automatic start_prog(input logic [5:0] h, input logic [7:0] l, input logic [7:0] cmd);
    wr(`FPEC_OFS_ADDRH, 32'(h));
    wr(`FPEC_OFS_ADDRL, 32'(l));
    wr(`FPEC_OFS_CTRL, 32'(cmd));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_prog;
    logic [31:0] q;
    dma_cnt = 0;
    wr(`FPEC_OFS_IRQ_MASK, 32'h04);
    start_prog(6'h05, 8'hFF, 8'h02);
    wr(`FPEC_OFS_WDATA, 32'h34);
    wr(`FPEC_OFS_WDATA, 32'h12);
    bus(1'b0, `FPEC_OFS_CTRL, 32'h0, q);
    chk(32'(q[7:6]), 32'h3);
    meas(1'b0);
    chk(32'(c.addr), 32'h5FF);
    chk(32'(c.wdata), 32'h1234);
    wr(`FPEC_OFS_WDATA, 32'hFF);
    wr(`FPEC_OFS_WDATA, 32'h00);
    meas(1'b0);
    chk(32'(c.addr), 32'h600);
    chk(32'(len), 32'd15);
    repeat (80) @(negedge sys_clk);
    chk(32'(dma_cnt), 32'd5);
    chk(32'(irq), 32'h1);
    rdchk(`FPEC_OFS_ADDRH, 32'h06);
    rdchk(`FPEC_OFS_ADDRL, 32'h01);
    rdchk(`FPEC_OFS_IRQ_STAT, 32'h05);
    wr(`FPEC_OFS_IRQ_STAT, 32'h07);
    @(negedge sys_clk);
    chk(32'(irq), 32'h0);
    start_prog(6'h05, 8'hFF, 8'h02);
    wr(`FPEC_OFS_WDATA, 32'hFF);
    wr(`FPEC_OFS_WDATA, 32'hFF);
    meas(1'b0);
    chk(32'(c.wdata), 32'h1234);
    repeat (80) @(negedge sys_clk);
    cpu_chk(15'h0BFE, 8'h34);
    cpu_chk(15'h0BFF, 8'h12);
  endtask
  task automatic t_combo;
    start_prog(6'h05, 8'hFF, 8'h03);
    meas(1'b1);
    chk(32'(c.addr), 32'h400);
    chk(32'(c.prog), 32'h0);
    chk(32'(len), 32'd20);
    wr(`FPEC_OFS_WDATA, 32'hAA);
    wr(`FPEC_OFS_WDATA, 32'h55);
    meas(1'b0);
    chk(32'(c.addr), 32'h5FF);
    chk(32'(c.wdata), 32'h55AA);
    repeat (80) @(negedge sys_clk);
    rdchk(`FPEC_OFS_IRQ_STAT, 32'h07);
    wr(`FPEC_OFS_IRQ_STAT, 32'h07);
  endtask
  task automatic t_chip;
    @(posedge sys_clk);
    dbg_chip_erase <= 1'b1;
    @(posedge sys_clk);
    dbg_chip_erase <= 1'b0;
    meas(1'b1);
    chk(32'(c.chip), 32'h1);
    chk(32'(len), 32'd40);
    cpu_chk(15'h0BFF, 8'hFF);
  endtask
  task automatic t_pwr;
    @(posedge sys_clk);
    avs_byteenable <= 4'hE;
    wr(`FPEC_OFS_TIMING, 32'h3F);
    rdchk(`FPEC_OFS_TIMING, 32'h01);
    @(posedge sys_clk);
    avs_byteenable <= 4'hF;
    wr(`FPEC_OFS_CLKDIV, 32'h01);
    repeat (3) @(negedge sys_clk);
    chk(32'(flash_pwr_dn), 32'h1);
    @(posedge sys_clk);
    cpu_rd <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(32'(flash_pwr_dn), 32'h0);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    {sys_clk, avs_read, avs_write, dbg_chip_erase, cpu_rd} = '0;
    {mismatches, n_checks, dma_cnt, len} = '0;
    avs_address = 5'h00;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    cpu_rd_addr = 15'h0000;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(`FPEC_OFS_TIMING, 32'h11);
    rdchk(`FPEC_OFS_CTRL, 32'h00);
    rdchk(`FPEC_OFS_WDATA, 32'h00);
    chk(32'(irq), 32'h0);
    wr(`FPEC_OFS_TIMING, 32'h01);
    t_prog();
    t_combo();
    t_chip();
    t_pwr();
    give_verdict();
  end
endmodule
`default_nettype wire
